/* src/bus_iface_pkg.sv */
// Shared constants and carrier types for the processor bus interface
package bus_iface_pkg;

    localparam int unsigned CLK_PERIOD_NS  = 25;
    localparam int unsigned RESET_FLOAT_CLKS = 5;      // outputs reach reset state within this
    localparam int unsigned RESET_MIN_CLKS = 5;
    localparam int unsigned BOOT_DELAY_CLKS = 3;
    localparam int unsigned RETAKE_CLKS    = 2;
    localparam int unsigned TRANS_MIN_CLKS = 3;
    localparam int unsigned BUS_WIDTH      = 16;
    localparam int unsigned SEG_WIDTH      = 7;
    localparam int unsigned SEG_COUNT      = 128;
    localparam int unsigned BOOT_WORDS     = 4;        // status words read at start-up
    localparam logic [15:0] BOOT_ADDR      = 16'h0000;

    typedef enum logic [3:0] {
        TT_INTERNAL   = 4'h0,
        TT_REFRESH    = 4'h1,
        TT_IO         = 4'h2,
        TT_SPECIAL_IO = 4'h3,
        TT_SEG_TRAP   = 4'h4,
        TT_NMI_ACK    = 4'h5,
        TT_NVI_ACK    = 4'h6,
        TT_VI_ACK     = 4'h7,
        TT_DATA       = 4'h8,
        TT_STACK      = 4'h9,
        TT_DATA_EXT   = 4'ha,
        TT_STACK_EXT  = 4'hb,
        TT_INSTR      = 4'hc,
        TT_FETCH1     = 4'hd,
        TT_EXT_XFER   = 4'he,
        TT_RESERVED   = 4'hf
    } trans_type_type;

    // One request from the core
    typedef struct packed {
        trans_type_type ttype;
        logic           read;
        logic           byte_size;
        logic           normal;
        logic [6:0]     segment;
        logic [15:0]    offset;
        logic [15:0]    wdata;
        logic [3:0]     idle_clks;   // machine-cycle tail after the transaction
    } request_type;

    // Pins driven by the device
    typedef struct packed {
        logic        address_strobe_n;
        logic        data_strobe_n;
        logic        memory_request_n;
        logic        bus_grant_n;
        logic        resource_claim_out_n;
        logic [3:0]  transaction_type_lines;
        logic        read_write;
        logic        byte_word;
        logic        normal_system;
        logic [6:0]  segment_number;
        logic [15:0] mux_bus_out;
        logic        mux_bus_oe_n;
        logic        ctrl_oe_n;       // strobes, type and control lines
    } pins_out_type;

    typedef enum logic [7:0] {
        ST_RESET   = 8'h01,
        ST_IDLE    = 8'h02,
        ST_ADDR    = 8'h04,
        ST_DATA    = 8'h08,
        ST_END     = 8'h10,
        ST_TAIL    = 8'h20,
        ST_FLOAT   = 8'h40,
        ST_GRANTED = 8'h80
    } bus_state_type;

endpackage

/* src/bus_iface.sv */
// Bus interface engine: reset, transactions, wait, stop, hold and resource lines
// Contract
// - Reset begins at end of any clock where reset input sampled low.
// - Reset overrides everything: interrupts, traps, hold and stop requests; code holds seg_trap low during reset by forcing trap_sync high.
// - Within five clocks of reset: bus floats, strobes/grant/type high, segment low.
// - Three clocks after reset release, system-mode back-to-back reads load status.
// - Type codes 0000-0111: internal, refresh, I/O, special, acknowledges.
// - Memory data 1000, stack 1001; extension-unit variants 1010 and 1011.
// - First fetch word 1101, other instruction access 1100, extension transfer 1110.
// - Read/write line high for read, low for write.
// - Byte/word line high for byte, low for word.
// - Mode line high in normal mode, low in system mode.
// - Type information presented before the data phase.
// - Sixteen lines carry address then data; strobes mark the phase.
// - Segmented address is seven segment bits plus sixteen offset bits.
// - Segment number valid before offset appears on multiplexed lines; code drives both in the same clock.
// - Wait low holds the transaction mid-way, adding clocks.
// - Stop halts after first fetch word, second word for extension instructions; code halts after any 1101 or 1100 word.
// - On hold request float lines first, then assert grant.
// - Resource claim output and status input give exclusive shared resource use.
// - Transaction lasts three or more clocks, address strobe fall to data strobe rise.
// - Machine cycle starts with a transaction and may run further clocks.
// - Hold request synchronised; low at cycle start gives grant after cycle.
// - Bus retaken two clocks after hold request rises; requester waits two clocks.
// - Stop sampled on falling edge before an initial fetch cycle.
`timescale 1ns/1ps

module bus_iface (
    input  wire logic                       clk,
    input  wire logic                       nrst,
    input  wire logic                       wait_n,
    input  wire logic                       stop_n,
    input  wire logic                       bus_hold_request_n,
    input  wire logic                       resource_status_in_n,
    input  wire logic                       translation_fault_trap_n,
    input  wire logic                       segmented,
    input  wire logic [15:0]                mux_bus_in,
    input  wire logic                       req_valid,
    input  wire bus_iface_pkg::request_type req,
    input  wire logic                       resource_claim,
    output logic                            req_ready,
    output logic                            rsp_valid,
    output logic [15:0]                     rsp_data,
    output logic                            boot_busy,
    output logic                            stopped,
    output logic                            resource_granted,
    output logic                            seg_trap,
    output bus_iface_pkg::pins_out_type     pins
);

    typedef struct packed {
        logic [1:0]                   rst_sync;
        logic [1:0]                   wait_sync;
        logic [1:0]                   hold_sync;
        logic [1:0]                   mi_sync;
        logic [1:0]                   trap_sync;
        logic [1:0]                   in_rst_cnt;
        logic [2:0]                   in_rst_age;
        logic [1:0]                   boot_cnt;
        logic [2:0]                   boot_words;
        logic                         stop_seen;
        logic                         hold_latched;
        logic [1:0]                   retake_cnt;
        logic [3:0]                   tail_cnt;
        bus_iface_pkg::bus_state_type st;
        bus_iface_pkg::request_type   cur;
        bus_iface_pkg::pins_out_type  po;
        logic                         rsp_valid;
        logic [15:0]                  rsp_data;
    } state_type;

    state_type s;
    state_type next_s;
    logic      stop_fall;

    // Stop is taken on the falling edge, then held for the core clock
    always_ff @(negedge clk) begin
        stop_fall <= stop_n;
    end

    function automatic bus_iface_pkg::pins_out_type idle_pins(input logic grant_n);
        bus_iface_pkg::pins_out_type p;
        p = '0;
        p.address_strobe_n       = 1'b1;
        p.data_strobe_n          = 1'b1;
        p.memory_request_n       = 1'b1;
        p.bus_grant_n            = grant_n;
        p.resource_claim_out_n   = 1'b1;
        p.transaction_type_lines = 4'hf;
        p.mux_bus_oe_n           = 1'b1;
        p.ctrl_oe_n              = 1'b0;
        return p;
    endfunction

    always_comb begin
        next_s = s;
        next_s.rsp_valid = 1'b0;
        next_s.rst_sync  = {s.rst_sync[0], nrst};
        next_s.wait_sync = {s.wait_sync[0], wait_n};
        next_s.hold_sync = {s.hold_sync[0], bus_hold_request_n};
        next_s.mi_sync   = {s.mi_sync[0], resource_status_in_n};
        next_s.trap_sync = {s.trap_sync[0], translation_fault_trap_n};
        if (!s.rst_sync[1]) begin
            // Reset wins over the engine state and pins; the register reset also forces seg_trap and resource_granted low
            next_s.st         = bus_iface_pkg::ST_RESET;
            next_s.po         = idle_pins(1'b1);
            next_s.boot_cnt   = '0;
            next_s.boot_words = '0;
            next_s.stop_seen  = 1'b0;
            next_s.hold_latched = 1'b0;
        end else begin
            case (s.st)
                bus_iface_pkg::ST_RESET: begin
                    // Counted from release so start-up reads begin three clocks later
                    next_s.boot_cnt = s.boot_cnt + 2'd1;
                    if (s.boot_cnt == 2'(bus_iface_pkg::BOOT_DELAY_CLKS - 1)) begin
                        next_s.st = bus_iface_pkg::ST_IDLE;
                    end
                end
                bus_iface_pkg::ST_IDLE: begin
                    next_s.po = idle_pins(1'b1);
                    // Stop may outlast the tail; without this the engine never restarts
                    if (s.stop_seen && stop_fall) begin
                        next_s.stop_seen = 1'b0;
                    end
                    if (!s.hold_sync[1]) begin
                        next_s.st = bus_iface_pkg::ST_FLOAT;
                    end else if (boot_busy || (req_valid && !s.stop_seen)) begin
                        if (boot_busy) begin
                            next_s.cur = '0;
                            next_s.cur.ttype  = bus_iface_pkg::TT_DATA;
                            next_s.cur.read   = 1'b1;
                            next_s.cur.offset = bus_iface_pkg::BOOT_ADDR
                                                + {12'h000, s.boot_words, 1'b0};
                        end else begin
                            next_s.cur = req;
                            if (req.ttype == bus_iface_pkg::TT_RESERVED) begin
                                next_s.cur.ttype = bus_iface_pkg::TT_INTERNAL;
                            end
                        end
                        next_s.hold_latched = 1'b0;
                        // Type, mode, size and segment change in the same clock as the strobe falls
                        next_s.po.transaction_type_lines = next_s.cur.ttype;
                        next_s.po.read_write    = next_s.cur.read;
                        next_s.po.byte_word     = next_s.cur.byte_size;
                        next_s.po.normal_system = boot_busy ? 1'b0 : next_s.cur.normal;
                        next_s.po.segment_number = segmented ? next_s.cur.segment : 7'h00;
                        next_s.po.memory_request_n = ~next_s.cur.ttype[3];
                        next_s.po.mux_bus_out  = next_s.cur.offset;
                        next_s.po.mux_bus_oe_n = 1'b0;
                        next_s.po.address_strobe_n = 1'b0;
                        next_s.st = bus_iface_pkg::ST_ADDR;
                    end
                end
                bus_iface_pkg::ST_ADDR: begin
                    // Hold sampled at start of machine cycle
                    next_s.hold_latched = ~s.hold_sync[1];
                    next_s.po.address_strobe_n = 1'b1;
                    next_s.po.data_strobe_n    = 1'b0;
                    next_s.po.mux_bus_out  = s.cur.wdata;
                    next_s.po.mux_bus_oe_n = s.cur.read;
                    next_s.st = bus_iface_pkg::ST_DATA;
                end
                bus_iface_pkg::ST_DATA: begin
                    if (s.wait_sync[1]) begin
                        next_s.st = bus_iface_pkg::ST_END;
                    end
                end
                bus_iface_pkg::ST_END: begin
                    // Third clock at least: data strobe rises here
                    next_s.po.data_strobe_n    = 1'b1;
                    next_s.po.memory_request_n = 1'b1;
                    next_s.po.mux_bus_oe_n     = 1'b1;
                    next_s.rsp_valid = 1'b1;
                    next_s.rsp_data  = mux_bus_in;
                    next_s.tail_cnt  = s.cur.idle_clks;
                    if (boot_busy) begin
                        next_s.boot_words = s.boot_words + 3'd1;
                    end
                    if (s.cur.ttype == bus_iface_pkg::TT_FETCH1
                        || s.cur.ttype == bus_iface_pkg::TT_INSTR) begin
                        next_s.stop_seen = ~stop_fall;
                    end
                    next_s.st = bus_iface_pkg::ST_TAIL;
                end
                bus_iface_pkg::ST_TAIL: begin
                    next_s.tail_cnt = s.tail_cnt - 4'd1;
                    if (s.stop_seen && stop_fall) begin
                        next_s.stop_seen = 1'b0;
                    end
                    if (s.tail_cnt == 4'd0) begin
                        next_s.st = s.hold_latched ? bus_iface_pkg::ST_FLOAT
                                                   : bus_iface_pkg::ST_IDLE;
                    end
                end
                bus_iface_pkg::ST_FLOAT: begin
                    // Float first, grant on the next clock
                    next_s.po = idle_pins(1'b1);
                    next_s.po.ctrl_oe_n = 1'b1;
                    next_s.st = bus_iface_pkg::ST_GRANTED;
                end
                bus_iface_pkg::ST_GRANTED: begin
                    next_s.po.bus_grant_n = 1'b0;
                    if (s.hold_sync[1]) begin
                        next_s.retake_cnt = s.retake_cnt + 2'd1;
                        if (s.retake_cnt == 2'(bus_iface_pkg::RETAKE_CLKS - 1)) begin
                            next_s.po = idle_pins(1'b1);
                            next_s.retake_cnt = '0;
                            next_s.st = bus_iface_pkg::ST_IDLE;
                        end
                    end else begin
                        next_s.retake_cnt = '0;
                    end
                end
                default: begin
                    next_s.st = bus_iface_pkg::ST_RESET;
                end
            endcase
            // Claim line stays driven in idle and while the bus is granted away
            next_s.po.resource_claim_out_n = ~resource_claim;
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst && !s.rst_sync[0] && !s.rst_sync[1]) begin
            s <= '0;
            s.st <= bus_iface_pkg::ST_RESET;
            s.po <= idle_pins(1'b1);
            s.wait_sync <= 2'b11;
            s.hold_sync <= 2'b11;
            s.mi_sync   <= 2'b11;
            s.trap_sync <= 2'b11;
        end else begin
            s <= next_s;
        end
    end

    assign boot_busy = (s.st != bus_iface_pkg::ST_RESET)
                       && (s.boot_words < 3'(bus_iface_pkg::BOOT_WORDS));
    assign req_ready = (s.st == bus_iface_pkg::ST_IDLE) && s.hold_sync[1]
                       && !boot_busy && !s.stop_seen;
    assign rsp_valid = s.rsp_valid;
    assign rsp_data  = s.rsp_data;
    assign stopped   = s.stop_seen;
    assign resource_granted = resource_claim && !s.mi_sync[1];
    assign seg_trap  = !s.trap_sync[1];
    assign pins      = s.po;

    a_reset_float: assert property (@(posedge clk)
        !nrst [*3] |=> pins.mux_bus_oe_n && pins.address_strobe_n
                       && pins.transaction_type_lines == 4'hf
                       && pins.segment_number == 7'h00)
        else $error("outputs not in reset state after reset");

    a_no_reserved: assert property (@(posedge clk) disable iff (!nrst)
        !pins.address_strobe_n |-> pins.transaction_type_lines != 4'hf)
        else $error("reserved type code driven");

    sequence addr_phase;
        $fell(pins.address_strobe_n);
    endsequence
    sequence type_steady;
        ##1 $stable(pins.transaction_type_lines) ##1 $stable(pins.transaction_type_lines);
    endsequence
    a_trans_length: assert property (@(posedge clk) disable iff (!nrst)
        addr_phase |-> ##1 pins.data_strobe_n == 1'b0 ##1 pins.data_strobe_n == 1'b0)
        else $error("transaction shorter than three clocks");

    a_wait_hold: assert property (@(posedge clk) disable iff (!nrst)
        s.st == bus_iface_pkg::ST_DATA && !s.wait_sync[1]
        |=> s.st == bus_iface_pkg::ST_DATA && !pins.data_strobe_n)
        else $error("wait did not stretch transaction");

    a_float_grant: assert property (@(posedge clk) disable iff (!nrst)
        $fell(pins.bus_grant_n) |-> pins.ctrl_oe_n && pins.mux_bus_oe_n
                                    && $past(pins.ctrl_oe_n))
        else $error("grant asserted before lines floated");

    a_retake_two: assert property (@(posedge clk) disable iff (!nrst)
        s.st == bus_iface_pkg::ST_GRANTED && s.hold_sync[1] && !$past(s.hold_sync[1])
        |-> ##2 s.st == bus_iface_pkg::ST_IDLE)
        else $error("bus not retaken two clocks after hold release");

    a_boot_system: assert property (@(posedge clk) disable iff (!nrst)
        addr_phase and boot_busy |-> !pins.normal_system && pins.read_write)
        else $error("start-up read not a system-mode read");

    a_type_lead: assert property (@(posedge clk) disable iff (!nrst)
        addr_phase |-> type_steady)
        else $error("type not stable into data phase");

    a_stop_halts: assert property (@(posedge clk) disable iff (!nrst)
        s.stop_seen |-> !req_ready)
        else $error("request accepted while stopped");

endmodule

/* tb/bus_memory_model.sv */
// Memory-side partner: answers reads and stretches transactions with wait_n
`timescale 1ns/1ps

module bus_memory_model (
    input  wire logic                        clk,
    input  wire bus_iface_pkg::pins_out_type pins,
    input  wire logic [3:0]                  stall,
    output logic [15:0]                      data,
    output logic                             wait_n
);
    logic [15:0] addr;
    logic [15:0] last;
    logic [3:0]  left;
    logic        hold;
    logic        active;

    initial begin
        data = 16'h0000;
        last = 16'h0000;
        addr = 16'h0000;
        left = 4'h0;
        hold = 1'b0;
        active = 1'b0;
        wait_n = 1'b1;
    end

    always @(posedge clk) begin
        hold <= !pins.data_strobe_n;
        if (!pins.address_strobe_n) begin
            addr <= pins.mux_bus_out;
            left <= stall;
            active <= 1'b1;
        end else begin
            if (left != 4'h0)
                left <= left - 4'h1;
            if (hold && pins.data_strobe_n)
                active <= 1'b0;
        end
    end

    // Slow slave holds wait low ahead of its access: the input synchroniser needs the lead
    always @(negedge clk) begin
        wait_n <= active ? (left == 4'h0) : (stall == 4'h0);
        if ((!pins.data_strobe_n || hold) && pins.read_write) begin
            data <= {addr[7:0], ~addr[15:8]};
            last <= {addr[7:0], ~addr[15:8]};
        end else begin
            data <= ~last;
        end
    end
endmodule

/* tb/bus_iface_test.sv */
// Self-checking bench for the processor bus interface
`timescale 1ns/1ps

module bus_iface_test;
    logic                           clk;
    logic                           nrst;
    logic                           wait_n;
    logic                           stop_n;
    logic                           hold_n;
    logic                           status_n;
    logic                           trap_n;
    logic                           segmented;
    logic [15:0]                    bus_in;
    logic                           req_valid;
    bus_iface_pkg::request_type     req;
    logic                           claim;
    logic                           req_ready;
    logic                           rsp_valid;
    logic [15:0]                    rsp_data;
    logic                           boot_busy;
    logic                           stopped;
    logic                           granted;
    logic                           seg_trap;
    bus_iface_pkg::pins_out_type    pins;
    logic [3:0]                     stall;
    logic [31:0]                    rnd;
    int                             err_total;
    int                             checks_done;

    bus_iface uut (.clk(clk), .nrst(nrst), .wait_n(wait_n), .stop_n(stop_n),
        .bus_hold_request_n(hold_n), .resource_status_in_n(status_n),
        .translation_fault_trap_n(trap_n), .segmented(segmented), .mux_bus_in(bus_in),
        .req_valid(req_valid), .req(req), .resource_claim(claim), .req_ready(req_ready),
        .rsp_valid(rsp_valid), .rsp_data(rsp_data), .boot_busy(boot_busy),
        .stopped(stopped), .resource_granted(granted), .seg_trap(seg_trap), .pins(pins));

    bus_memory_model mem (.clk(clk), .pins(pins), .stall(stall), .data(bus_in),
        .wait_n(wait_n));

    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    task automatic tick;
        @(posedge clk);
        #2;
    endtask

    task automatic check(input string name, input logic [16:0] exp, input logic [16:0] got);
        checks_done++;
        if (got !== exp) begin
            err_total++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic print_verdict;
        $display("checks_done=%0d err_total=%0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    // Reset source keeps the line low five clocks
    task automatic do_reset;
        nrst = 1'b0;
        repeat (5) tick;
        check("idle", {5'h1f, 4'hf, 7'h00, 1'b1}, {pins.address_strobe_n,
            pins.data_strobe_n, pins.memory_request_n, pins.bus_grant_n,
            pins.resource_claim_out_n, pins.transaction_type_lines, pins.segment_number,
            pins.mux_bus_oe_n});
        nrst = 1'b1;
    endtask

    task automatic do_req(input bus_iface_pkg::request_type r);
        int n;
        logic [3:0] t;
        n = 0;
        while (req_ready !== 1'b1 && n < 60) begin
            tick;
            n++;
        end
        check("ready", 17'h1, {16'h0, req_ready});
        req = r;
        req_valid = 1'b1;
        tick;
        req_valid = 1'b0;
        n = 0;
        while (pins.address_strobe_n !== 1'b0 && n < 8) begin
            tick;
            n++;
        end
        t = (r.ttype == 4'hf) ? 4'h0 : r.ttype;
        check("type", {13'h0, t}, {13'h0, pins.transaction_type_lines});
        check("memory_request_n", {16'h0, ~t[3]}, {16'h0, pins.memory_request_n});
        check("rw", {16'h0, r.read}, {16'h0, pins.read_write});
        check("bw", {16'h0, r.byte_size}, {16'h0, pins.byte_word});
        check("ns", {16'h0, r.normal}, {16'h0, pins.normal_system});
        check("seg", {10'h0, segmented ? r.segment : 7'h00}, {10'h0, pins.segment_number});
        check("addr", {1'b0, r.offset}, {pins.mux_bus_oe_n, pins.mux_bus_out});
        n = 0;
        while (rsp_valid !== 1'b1 && n < 40) begin
            tick;
            n++;
            if (pins.data_strobe_n === 1'b0 && !r.read)
                check("wdata", {1'b0, r.wdata}, {pins.mux_bus_oe_n, pins.mux_bus_out});
        end
        check("len", 17'h1, {16'h0, n >= 3 && rsp_valid === 1'b1});
        check("stretch", 17'h1, {16'h0, (stall == 4'h0) ? (n == 3) : (n > 3)});
        if (r.read)
            check("rdata", {1'b0, r.offset[7:0], ~r.offset[15:8]}, {1'b0, rsp_data});
    endtask

    initial begin
        #(25 * 20000);
        err_total++;
        print_verdict;
    end

    initial begin
        bus_iface_pkg::request_type r;
        int n;
        int words;
        int first;
        {nrst, stop_n, hold_n, status_n, trap_n, segmented, req_valid, claim} = 8'h7c;
        req = '0;
        stall = 4'h0;
        err_total = 0;
        checks_done = 0;
        rnd = 32'h60d8;
        do_reset;
        words = 0;
        first = -1;
        for (n = 1; n <= 60; n++) begin
            tick;
            if (pins.address_strobe_n === 1'b0) begin
                words++;
                if (first < 0)
                    first = n;
                check("boot", 17'h1, {15'h0, pins.normal_system, pins.read_write});
            end
        end
        check("boot_n", 17'(bus_iface_pkg::BOOT_WORDS), 17'(words));
        check("boot_busy", 17'h0, {16'h0, boot_busy});
        check("boot_t", 17'h1, {16'h0, first >= 3});
        for (int i = 0; i < 40; i++) begin
            rnd = lfsr(rnd);
            r.ttype = bus_iface_pkg::trans_type_type'(i[3:0]);
            {r.read, r.byte_size, r.normal, segmented} = rnd[3:0];
            r.segment = (i >= 32) ? 7'h7f : rnd[10:4];
            r.offset = (i >= 32) ? 16'hffff : rnd[31:16];
            r.wdata = ~rnd[15:0];
            r.idle_clks = {2'b00, rnd[12:11]};
            stall = (i >= 36) ? 4'h8 : {1'b0, rnd[15:13]};
            do_req(r);
        end
        stall = 4'h0;
        hold_n = 1'b0;
        n = 0;
        while (pins.bus_grant_n !== 1'b0 && n < 40) begin
            tick;
            n++;
        end
        check("float", {14'h0, 3'b011}, {14'h0, pins.bus_grant_n, pins.ctrl_oe_n,
            pins.mux_bus_oe_n});
        check("busy", 17'h0, {16'h0, req_ready});
        hold_n = 1'b1;
        n = 0;
        while (pins.bus_grant_n !== 1'b1 && n < 20) begin
            tick;
            n++;
        end
        check("retake", 17'h1, {16'h0, n <= 4});
        repeat (2) tick;
        stop_n = 1'b0;
        r.ttype = bus_iface_pkg::TT_FETCH1;
        r.read = 1'b1;
        do_req(r);
        n = 0;
        while (stopped !== 1'b1 && n < 20) begin
            tick;
            n++;
        end
        check("stop", 17'h1, {16'h0, stopped});
        repeat (8) tick;
        check("held", 17'h1, {16'h0, stopped && !req_ready});
        stop_n = 1'b1;
        repeat (20) tick;
        check("run", 17'h0, {16'h0, stopped});
        claim = 1'b1;
        repeat (2) tick;
        check("claim", 17'h0, {16'h0, pins.resource_claim_out_n});
        status_n = 1'b0;
        trap_n = 1'b0;
        repeat (4) tick;
        check("res", 17'h3, {15'h0, granted, seg_trap});
        claim = 1'b0;
        trap_n = 1'b1;
        r.ttype = bus_iface_pkg::TT_DATA;
        req = r;
        req_valid = 1'b1;
        tick;
        req_valid = 1'b0;
        hold_n = 1'b0;
        stop_n = 1'b0;
        do_reset;
        hold_n = 1'b1;
        stop_n = 1'b1;
        repeat (60) tick;
        print_verdict;
    end
endmodule
